// ===== dv/osc_startup_timer_pll_enable_tb.sv
`include "ostpll_params.svh"
`default_nettype none
module osc_startup_timer_pll_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0; // system clock
  logic        rst_i     = 1'b1; // power-on reset
  logic        pin;              // resonator output
  logic [2:0]  mode      = 3'h1; // configured source
  logic        powerup_delay_timer_en   = 1'b1; // power-up delay fitted
  logic        fuse      = 1'b0; // config multiplier bit
  logic        wake      = 1'b0; // wake pulse
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [7:0]  half      = 8'd19; // resonator half period less 1 ns
  logic [31:0] rdata;
  logic        hold, stat, mult, ext;
  int          bad_count = 0;
  int          comparisons = 0;
  int          rises = 0; // pin rises since last wake
  always #4 sys_clk_i = ~sys_clk_i;
  always @(posedge pin) rises++;
  ostpll_xtal u_xtal (.half_ns_i(half), .osc_o(pin));
  ostpll_top #(.STARTUP_CYCLES(8), .POWERUP_CYCLES(4)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .oscillator_input_pin_i(pin), .osc_mode_i(mode),
    .powerup_delay_en_i(powerup_delay_timer_en), .multiplier_fuse_enable_i(fuse),
    .wake_i(wake), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .core_hold_o(hold),
    .startup_timeout_status_o(stat), .multiplier_enable_o(mult),
    .ext_clk_sel_o(ext));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one-cycle register write
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  // reset held for 16 cycles with a given source
  task automatic do_reset(input logic [2:0] m);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    mode <= m;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 check({stat, hold}, 2'b01);
  endtask
  // bounded wait for the count to finish
  task automatic wait_stat;
    for (int i = 0; i < 3000 && stat !== 1'b1; i++)
      @(posedge sys_clk_i);
    #1 if (stat !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  // wake pulse, status must clear and core hold
  task automatic pulse_wake;
    @(posedge sys_clk_i);
    wake <= 1'b1;
    @(posedge sys_clk_i);
    wake <= 1'b0;
    rises = 0;
    #1 check({stat, hold}, 2'b01);
  endtask
  initial begin
    // each crystal mode: count after reset, then after wake
    for (int m = 0; m < 3; m++) begin
      do_reset(3'(m));
      wait_stat();
      check(hold, 1'b0);
      @(posedge sys_clk_i);
      #1 check(ext, 1'b1);
      pulse_wake();
      wait_stat();
      check(32'(rises >= 8 && rises <= 10), 32'h1);
      $display("crystal mode %0d done", m);
    end
    // slow resonator, second wake mid-count restarts
    half = 8'd39;
    pulse_wake();
    repeat (20) @(posedge sys_clk_i);
    reg_rd(`OSTPLL_OFS_STAT, 32'hc);
    pulse_wake();
    wait_stat();
    check(32'(rises >= 8 && rises <= 10), 32'h1);
    reg_rd(`OSTPLL_OFS_STAT, 32'h1);
    reg_rd(`OSTPLL_OFS_COUNT, 32'h0);
    $display("restart done");
    // internal source: no count, core runs
    powerup_delay_timer_en <= 1'b0;
    do_reset(3'h4);
    repeat (20) @(posedge sys_clk_i);
    #1 check({stat, hold}, 2'b00);
    #1 check(ext, 1'b0);
    $display("internal source done");
    // multiplier by soft bit, then by fuse
    reg_rd(`OSTPLL_OFS_CTRL, 32'h0);
    reg_wr(`OSTPLL_OFS_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    #1 check(mult, 1'b1);
    reg_rd(`OSTPLL_OFS_CTRL, 32'h1);
    @(posedge sys_clk_i);
    fuse <= 1'b1;
    reg_wr(`OSTPLL_OFS_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    #1 check(mult, 1'b1);
    reg_rd(`OSTPLL_OFS_STAT, 32'h2);
    @(posedge sys_clk_i);
    fuse <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 check(mult, 1'b0);
    reg_rd(8'h10, 32'h0);
    $display("multiplier done");
    finish_test();
  end
endmodule // osc_startup_timer_pll_enable_tb
bind ostpll_top ostpll_props u_props (.*);
`default_nettype wire

// ===== dv/ostpll_properties.sv
`default_nettype none
module ostpll_props (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [2:0]  osc_mode_i,
  input wire logic        multiplier_fuse_enable_i,
  input wire logic        wake_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        core_hold_o,
  input wire logic        startup_timeout_status_o,
  input wire logic        multiplier_enable_o,
  input wire logic        ext_clk_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // wake-up seen while a crystal source is configured
  sequence s_wake_xtal;
    wake_i && osc_mode_i <= 3'h2;
  endsequence
  // count just finished
  sequence s_done;
    $rose(startup_timeout_status_o);
  endsequence
  AST_FUSE_FORCE: assert property (
    multiplier_fuse_enable_i |=> multiplier_enable_o)
    else $error("fuse set but multiplier off");
  AST_SOFT_ON: assert property ($rose(multiplier_enable_o) &&
    !multiplier_fuse_enable_i |-> $past(wr_i && addr_i == 8'h00 && wdata_i[0], 2))
    else $error("multiplier rose without soft write");
  AST_HOLD_STAT: assert property (
    startup_timeout_status_o |-> !core_hold_o)
    else $error("core held after count done");
  AST_STAT_XTAL: assert property (
    startup_timeout_status_o |-> osc_mode_i <= 3'h2)
    else $error("status set in non crystal mode");
  AST_WAKE_CLR: assert property (s_wake_xtal |=> !startup_timeout_status_o)
    else $error("status not cleared by wake");
  AST_WAKE_HOLD: assert property (s_wake_xtal |=> core_hold_o [*8])
    else $error("core released too early after wake");
  AST_MIN_COUNT: assert property (s_done |-> $past(core_hold_o, 15))
    else $error("count finished too soon");
  AST_EXT_SEL: assert property (s_done |=> ext_clk_sel_o)
    else $error("external clock not selected");
  AST_HOLD_REL: assert property ($fell(core_hold_o) && osc_mode_i <= 3'h2
    |-> startup_timeout_status_o)
    else $error("hold dropped before count done");
endmodule // ostpll_props
`default_nettype wire

// ===== dv/ostpll_xtal.sv
`default_nettype none
module ostpll_xtal (
  input  wire logic [7:0] half_ns_i, // half period less 1 ns: small is prompt
  output var logic        osc_o      // resonator level at the pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // a resonator swings freely once powered
  initial begin
    osc_o = 1'b0;
    forever #(half_ns_i + 8'h1) osc_o = ~osc_o;
  end
endmodule // ostpll_xtal
`default_nettype wire

// ===== hw/ostpll_top.sv
// Contract
// RL1: crystal modes count 1024 oscillator cycles
// RL2: launch after power-up delay and wake
// RL3: hold the core while counting
// RL4: provide times-four multiplier enable for clock
// RL5: fuse bit or soft bit enables multiplier
// RL6: fuse set overrides soft bit value
// RL7: status shows start-up count finished
// RL8: each launch restarts count, clears status
`include "ostpll_params.svh"
`default_nettype none

// the block trusts a crystal only after a full count of its swings;
// the core stays held until then so no code runs on a bad clock.
// the multiplier enable is a plain or of the fuse and the soft bit,
// so the fuse can never be overridden from software.
module ostpll_top #(
  parameter int STARTUP_CYCLES = `OSTPLL_STARTUP_CYCLES,
  parameter int POWERUP_CYCLES = `OSTPLL_POWERUP_CYCLES,
  parameter int CNT_W          = 11,
  parameter int POWERUP_W      = 16
) (
  input  wire logic        sys_clk_i,            // system clock, 125 MHz
  input  wire logic        rst_i,                // power-on reset
  input  wire logic        oscillator_input_pin_i, // crystal pin level
  input  wire logic [2:0]  osc_mode_i,           // configured source
  input  wire logic        powerup_delay_en_i,   // delay fitted
  input  wire logic        multiplier_fuse_enable_i, // config bit
  input  wire logic        wake_i,               // wake-up pulse
  input  wire logic [7:0]  addr_i,               // register address
  input  wire logic [31:0] wdata_i,              // write data
  input  wire logic        wr_i,                 // write strobe
  input  wire logic        rd_i,                 // read strobe
  output logic      [31:0] rdata_o,              // read data, next cycle
  output logic             core_hold_o,          // stall program counter
  output logic             startup_timeout_status_o, // clock stable
  output logic             multiplier_enable_o,  // run times-four
  output logic             ext_clk_sel_o         // system on external
);

  // ---------------------------------------------------------------
  // decoding shared by several processes
  // ---------------------------------------------------------------

  // true for the three crystal or resonator modes
  function automatic logic is_crystal(input logic [2:0] m);
    case (m)
      ostpll_pkg::OSTPLL_MODE_LOW_POWER,
      ostpll_pkg::OSTPLL_MODE_STANDARD,
      ostpll_pkg::OSTPLL_MODE_HIGH_SPEED: is_crystal = 1'b1;
      default:                    is_crystal = 1'b0;
    endcase
  endfunction

  // true when the system clock comes from the pin side
  function automatic logic is_external(input logic [2:0] m);
    is_external = (m != ostpll_pkg::OSTPLL_MODE_INT);
  endfunction

  // terminal values at counter width
  // counting ends on the last value, so the full span is counted
  localparam logic [CNT_W-1:0]     STARTUP_LAST =
    CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [POWERUP_W-1:0] POWERUP_LAST =
    POWERUP_W'(POWERUP_CYCLES - 1);

  // ---------------------------------------------------------------
  // oscillator pin synchroniser
  // ---------------------------------------------------------------

  logic [2:0] pin_sync_r;     // three-stage shift of the pin
  logic [2:0] pin_sync_nxt;
  logic       pin_level_r;    // filtered level, updates on agreement
  logic       pin_level_nxt;
  logic       osc_edge;       // one pulse per oscillation

  // shift the pin in; stage 0 is seen only by stage 1
  always_comb begin
    pin_sync_nxt  = {pin_sync_r[1:0], oscillator_input_pin_i};
    pin_level_nxt = pin_level_r;
    // accept a new level once the last two stages agree
    if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_level_nxt = pin_sync_r[2];
    end
  end

  // register the synchroniser
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync_r  <= 3'h0;
      pin_level_r <= 1'b0;
    end else begin
      pin_sync_r  <= pin_sync_nxt;
      pin_level_r <= pin_level_nxt;
    end
  end

  // a rising oscillation is a low-to-high of the filtered level
  assign osc_edge = pin_level_nxt & ~pin_level_r;

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------

  ostpll_pkg::ostpll_state_t state_r;    // sequencer state
  ostpll_pkg::ostpll_state_t state_nxt;
  logic [CNT_W-1:0]     startup_cnt_r;   // oscillations seen
  logic [CNT_W-1:0]     startup_cnt_nxt;
  logic [POWERUP_W-1:0] powerup_cnt_r;   // power-up delay cycles
  logic [POWERUP_W-1:0] powerup_cnt_nxt;
  logic                 timeout_stat_r;  // start-up timeout status
  logic                 timeout_stat_nxt;
  logic              hold_r;             // core held
  logic              hold_nxt;
  logic              crystal;            // crystal mode selected

  assign crystal = is_crystal(osc_mode_i);

  // next state of the sequencer and its counters
  always_comb begin
    state_nxt        = state_r;
    startup_cnt_nxt  = startup_cnt_r;
    powerup_cnt_nxt  = powerup_cnt_r;
    timeout_stat_nxt = timeout_stat_r;
    hold_nxt         = hold_r;
    case (state_r)
      // waiting out the power-up delay after reset
      ostpll_pkg::OSTPLL_ST_POWERUP: begin
        hold_nxt = 1'b1;
        // a wake here is ignored: the launch follows anyway
        if (!powerup_delay_en_i || powerup_cnt_r == POWERUP_LAST) begin
          powerup_cnt_nxt = '0;
          state_nxt       = ostpll_pkg::OSTPLL_ST_IDLE;   // RL2
        end else begin
          powerup_cnt_nxt = powerup_cnt_r + POWERUP_W'(1);
        end
      end
      // decide whether the count is needed
      ostpll_pkg::OSTPLL_ST_IDLE: begin
        startup_cnt_nxt  = '0;                         // RL8
        timeout_stat_nxt = 1'b0;                       // RL8
        if (crystal) begin
          hold_nxt  = 1'b1;                            // RL3
          state_nxt = ostpll_pkg::OSTPLL_ST_COUNT;     // RL2
        end else begin
          hold_nxt  = 1'b0;
          state_nxt = ostpll_pkg::OSTPLL_ST_RUN;
        end
      end
      // counting crystal oscillations, core stalled
      ostpll_pkg::OSTPLL_ST_COUNT: begin
        hold_nxt = 1'b1;                               // RL3
        // a wake while counting starts the count over
        if (wake_i) begin
          startup_cnt_nxt = '0;                        // RL8
        end else if (osc_edge) begin
          if (startup_cnt_r == STARTUP_LAST) begin     // RL1
            startup_cnt_nxt  = '0;
            timeout_stat_nxt = 1'b1;                   // RL7
            hold_nxt         = 1'b0;                   // RL3
            state_nxt        = ostpll_pkg::OSTPLL_ST_RUN;
          end else begin
            startup_cnt_nxt = startup_cnt_r + CNT_W'(1);  // RL1
          end
        end
      end
      // running; a wake relaunches the count in crystal modes
      ostpll_pkg::OSTPLL_ST_RUN: begin
        hold_nxt = 1'b0;
        if (wake_i) begin
          state_nxt        = ostpll_pkg::OSTPLL_ST_IDLE;  // RL2
          timeout_stat_nxt = 1'b0;                        // RL8
          hold_nxt         = crystal;                     // RL3
        end
      end
      // unreachable encoding falls back to a fresh launch
      default: begin
        state_nxt = ostpll_pkg::OSTPLL_ST_IDLE;
        hold_nxt  = 1'b1;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r        <= ostpll_pkg::OSTPLL_ST_POWERUP;
      startup_cnt_r  <= '0;
      powerup_cnt_r  <= '0;
      timeout_stat_r <= 1'b0;
      hold_r         <= 1'b1;
    end else begin
      state_r        <= state_nxt;
      startup_cnt_r  <= startup_cnt_nxt;
      powerup_cnt_r  <= powerup_cnt_nxt;
      timeout_stat_r <= timeout_stat_nxt;
      hold_r         <= hold_nxt;
    end
  end

  // ---------------------------------------------------------------
  // multiplier enable
  // ---------------------------------------------------------------

  logic soft_en_r;     // soft multiplier enable, software owned
  logic soft_en_nxt;
  logic mult_r;        // multiplier enable towards the clock tree
  logic mult_nxt;
  logic ext_r;         // system clock from external side
  logic ext_nxt;

  // fuse wins; soft bit only matters while the fuse is clear
  always_comb begin
    soft_en_nxt = soft_en_r;
    if (wr_i && addr_i == `OSTPLL_OFS_CTRL) begin
      soft_en_nxt = wdata_i[`OSTPLL_CTRL_SOFT_BIT];
    end
    if (multiplier_fuse_enable_i) begin
      mult_nxt = 1'b1;                                 // RL6
    end else begin
      mult_nxt = soft_en_r;                            // RL5
    end
    // crystal sources count as external only once stable
    if (crystal) begin
      ext_nxt = timeout_stat_r;                        // RL7
    end else begin
      ext_nxt = is_external(osc_mode_i);
    end
  end

  // register the enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_en_r <= `OSTPLL_CTRL_RESET;
      mult_r    <= 1'b0;
      ext_r     <= 1'b0;
    end else begin
      soft_en_r <= soft_en_nxt;
      mult_r    <= mult_nxt;                           // RL4
      ext_r     <= ext_nxt;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------

  logic [31:0] rdata_r;    // read data, valid the cycle after rd_i
  logic [31:0] rdata_nxt;

  // decode the read; unmapped and idle cycles return zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (rd_i) begin
      case (addr_i)
        // control: soft enable
        `OSTPLL_OFS_CTRL: begin
          rdata_nxt[`OSTPLL_CTRL_SOFT_BIT] = soft_en_r;
        end
        // status: stability, multiplier, counting, hold
        `OSTPLL_OFS_STAT: begin
          rdata_nxt[`OSTPLL_STAT_TIMEOUT_BIT] = timeout_stat_r;  // RL7
          rdata_nxt[`OSTPLL_STAT_MULT_BIT] = mult_r;
          rdata_nxt[`OSTPLL_STAT_BUSY_BIT] =
            (state_r == ostpll_pkg::OSTPLL_ST_COUNT);
          rdata_nxt[`OSTPLL_STAT_HOLD_BIT] = hold_r;
        end
        // live oscillation count
        `OSTPLL_OFS_COUNT: begin
          rdata_nxt[CNT_W-1:0] = startup_cnt_r;
        end
        // anything else reads as zero
        default: begin
          rdata_nxt = 32'h0;
        end
      endcase
    end
  end

  // register the read data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ---------------------------------------------------------------

  assign rdata_o                  = rdata_r;
  assign core_hold_o              = hold_r;
  assign startup_timeout_status_o = timeout_stat_r;
  assign multiplier_enable_o      = mult_r;
  assign ext_clk_sel_o            = ext_r;

endmodule // ostpll_top

`default_nettype wire

// ===== shared/ostpll_params.svh
`ifndef OSTPLL_PARAMS_SVH
`define OSTPLL_PARAMS_SVH

// oscillator edges counted before the crystal is trusted
`define OSTPLL_STARTUP_CYCLES 1024
// power-up delay, in system clock cycles
`define OSTPLL_POWERUP_CYCLES 8192

// register offsets (byte addresses)
`define OSTPLL_OFS_CTRL       8'h00
`define OSTPLL_OFS_STAT       8'h04
`define OSTPLL_OFS_COUNT      8'h08

// field positions
`define OSTPLL_CTRL_SOFT_BIT  0
`define OSTPLL_STAT_TIMEOUT_BIT 0
`define OSTPLL_STAT_MULT_BIT  1
`define OSTPLL_STAT_BUSY_BIT  2
`define OSTPLL_STAT_HOLD_BIT  3

// reset values
`define OSTPLL_CTRL_RESET     1'b0

`endif

// ===== shared/ostpll_pkg.sv
`default_nettype none
package ostpll_pkg;

  // oscillator source selection from the configuration word
  typedef enum logic [2:0] {
    OSTPLL_MODE_LOW_POWER  = 3'b000,
    OSTPLL_MODE_STANDARD   = 3'b001,
    OSTPLL_MODE_HIGH_SPEED = 3'b010,
    OSTPLL_MODE_EXTRC = 3'b011,
    OSTPLL_MODE_INT   = 3'b100,
    OSTPLL_MODE_ECL   = 3'b101,
    OSTPLL_MODE_ECM   = 3'b110,
    OSTPLL_MODE_ECH   = 3'b111
  } ostpll_mode_t;

  // start-up sequencer states
  typedef enum logic [1:0] {
    OSTPLL_ST_POWERUP = 2'b00,
    OSTPLL_ST_COUNT = 2'b01,
    OSTPLL_ST_RUN   = 2'b10,
    OSTPLL_ST_IDLE  = 2'b11
  } ostpll_state_t;

endpackage : ostpll_pkg
`default_nettype wire
